// >>> dv/sld_host_model.sv
// host model: shifts serial words into the driver and pulses load
// assumes the bench calls its tasks just after a core_clk edge
module sld_host_model (
  input wire logic core_clk,
  output logic serialClk,
  output logic serialIn,
  output logic loadIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serialClk = 1'b1;
    serialIn = 1'b0;
    loadIn = 1'b0;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : waitCyc
  // first bit sent ends deepest; clock idles high between words
  task automatic sendBits(input logic [31:0] w, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      serialIn = w[i];
      waitCyc(4);
      serialClk = 1'b0;
      waitCyc(4);
      serialClk = 1'b1;
      waitCyc(4);
    end
    // data no longer valid once the word is over
    serialIn = ~w[32 - n];
    waitCyc(6);
  endtask : sendBits
  task automatic pulseLoad;
    loadIn = 1'b1;
    waitCyc(6);
    loadIn = 1'b0;
    waitCyc(4);
  endtask : pulseLoad
endmodule : sld_host_model

// >>> dv/tb_sld_driver.sv
// bench for the serial segment driver: host model plus osc pin drive
// assumes sld_pkg is compiled first; driven-sense timeout cut to 20
module tb_sld_driver import sld_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic oscPin = 1'b0;
  logic serialClk, serialIn, loadIn, serialOut, backplaneOut;
  logic [31:0] segOut;
  int errCount = 0;
  int nCompared = 0;
  int cycles = 0;
  `define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin \
    errCount++; $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
  always #25 core_clk = ~core_clk;
  // backplane output feeds no osc pin or other backplane here
  sld_driver #(.TIMEOUT_CYC(20)) u_sld_driver (
    .core_clk(core_clk), .rst(rst), .serialClk(serialClk),
    .serialIn(serialIn), .loadIn(loadIn), .backplane_osc_pin(oscPin),
    .serialOut(serialOut), .backplane_out(backplaneOut), .segOut(segOut));
  sld_host_model u_sld_host_model (.core_clk(core_clk),
    .serialClk(serialClk), .serialIn(serialIn), .loadIn(loadIn));
  task automatic summarize;
    if (errCount == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      errCount++;
      summarize();
    end
  end
  task automatic oscWait(input logic lvl, input int n);
    oscPin = lvl;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : oscWait
  // check both backplane phases, osc held still past the window
  task automatic checkSeg(input logic [31:0] w);
    for (int p = 0; p < 2; p++) begin
      oscWait(p[0], 25);
      `CHK("backplane", p[0], backplaneOut)
      `CHK("segOut", w ^ {32{p[0]}}, segOut)
    end
  endtask : checkSeg
  task automatic latchedWord;
    u_sld_host_model.sendBits(32'hA5C3_0F96, 32);
    `CHK("serialOut", 1'b1, serialOut)
    u_sld_host_model.pulseLoad();
    checkSeg(32'hA5C3_0F96);
  endtask : latchedWord
  task automatic heldOff;
    u_sld_host_model.sendBits(32'h3C5A_E187, 32);
    `CHK("serialOut", 1'b0, serialOut)
    checkSeg(32'hA5C3_0F96);
    u_sld_host_model.pulseLoad();
    checkSeg(32'h3C5A_E187);
  endtask : heldOff
  // osc last held high, so backplane is 1 and set bits read as 0
  task automatic transparent;
    u_sld_host_model.loadIn = 1'b1;
    u_sld_host_model.sendBits(32'hB00D_5EED, 10);
    `CHK("segBit9", 1'b0, segOut[9])
    `CHK("segBit8", 1'b1, segOut[8])
    u_sld_host_model.sendBits(32'hB00D_5EED << 10, 22);
    checkSeg(32'hB00D_5EED);
    u_sld_host_model.loadIn = 1'b0;
  endtask : transparent
  task automatic drivenPhase;
    for (int k = 0; k < 6; k++) begin
      oscWait(~oscPin, 25);
      `CHK("bpDriven", oscPin, backplaneOut)
    end
  endtask : drivenPhase
  // fast osc: edges inside the window mean an rc pin, backplane divides
  task automatic selfOsc;
    int last;
    int hits;
    logic bp;
    last = -1;
    hits = 0;
    // first edge after a quiet pin is still taken as driven
    repeat (2) begin
      oscWait(1'b1, 6);
      oscWait(1'b0, 6);
    end
    bp = backplaneOut;
    for (int n = 0; n < 70; n++) begin
      oscWait(1'b1, 6);
      oscWait(1'b0, 6);
      if (backplaneOut !== bp) begin
        if (last >= 0) begin
          hits++;
          `CHK("bpDiv", SLD_OSC_DIV / 2, n - last)
        end
        last = n;
        bp = backplaneOut;
      end
    end
    `CHK("bpDivHits", 1'b1, hits >= 3)
  endtask : selfOsc
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    latchedWord();
    heldOff();
    transparent();
    drivenPhase();
    selfOsc();
    summarize();
  end
endmodule : tb_sld_driver

// >>> rtl/sld_driver.sv
// serial-in, 32-segment lcd driver with backplane generation
// assumes serial clock, data, load and osc pin are async pins, sampled
// on core_clk; serial clock must be well below core_clk / 4
module sld_driver import sld_pkg::*; #(
  parameter int SEGS = SLD_SEG_COUNT,
  parameter int DIV = SLD_OSC_DIV,
  parameter int TIMEOUT_CYC = SLD_DRIVEN_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic loadIn,
  input wire logic backplane_osc_pin,
  output logic serialOut,
  output logic backplane_out,
  output logic [SEGS-1:0] segOut
);
  typedef enum logic [1:0] {
    OSC_SELF = 2'b01,
    OSC_DRIVEN = 2'b10
  } sld_osc_e;

  // two-flop synchronisers; stage one read only by stage two
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic [3:0] syncC_q;
  always_ff @(posedge core_clk) begin
    syncA_q <= {backplane_osc_pin, loadIn, serialIn, serialClk};
    syncB_q <= syncA_q;
    syncC_q <= syncB_q;
  end
  wire clkS = syncB_q[0];
  wire dataS = syncB_q[1];
  wire loadS = syncB_q[2];
  wire oscS = syncB_q[3];
  wire clkFall = syncC_q[0] && !clkS;
  wire clkRise = !syncC_q[0] && clkS;
  wire oscRise = !syncC_q[3] && oscS;
  wire oscEdge = syncC_q[3] != oscS;

  // captured bits pass through the fifo; shifting pops one per fall
  logic fifoReady;
  logic bitValid;
  logic bitData;
  sld_fifo #(.WIDTH(1), .DEPTH(SLD_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(clkFall),
    .inReady(fifoReady),
    .inData(dataS),
    .outValid(bitValid),
    .outReady(1'b1),
    .outData(bitData)
  );
  // fifo never holds more than one bit since it drains each cycle
  wire doShift = bitValid;

  logic [SEGS-1:0] shift_q;
  logic [SEGS-1:0] latch_q;
  logic serialOut_q;
  always_ff @(posedge core_clk) begin
    if (doShift) begin
      shift_q <= {shift_q[SEGS-2:0], bitData};
    end
  end
  wire [SEGS-1:0] shiftNext = doShift ? {shift_q[SEGS-2:0], bitData}
                                      : shift_q;
  always_ff @(posedge core_clk) begin
    if (loadS) begin
      latch_q <= shiftNext;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serialOut_q <= 1'b0;
    end else if (clkRise) begin
      serialOut_q <= shift_q[SEGS-1];
    end
  end
  assign serialOut = serialOut_q;

  // oscillator mode sensing and backplane phase
  logic [11:0] idle_q;
  logic [4:0] div_q;
  logic bpPhase_q;
  sld_osc_e oscMode;
  wire timedOut = idle_q == 12'(TIMEOUT_CYC);
  // an rc pin toggles well inside the window; a slow external drive
  // leaves the pin quiet past it, so a quiet pin is taken as driven
  assign oscMode = timedOut ? OSC_DRIVEN : OSC_SELF;
  always_ff @(posedge core_clk) begin
    if (rst || oscEdge) begin
      idle_q <= SLD_TIMEOUT_RST;
    end else if (!timedOut) begin
      idle_q <= idle_q + 12'h001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_q <= SLD_DIV_RST;
    end else if (oscRise) begin
      div_q <= (div_q == 5'(DIV/2 - 1)) ? SLD_DIV_RST : div_q + 5'h01;
    end
  end
  // self mode toggles once per 16 rises; an external drive faster
  // than the window is mistaken for an rc pin, a known limitation
  wire divWrap = oscRise && (div_q == 5'(DIV/2 - 1));
  logic bpNext;
  always_comb begin
    bpNext = bpPhase_q;
    unique case (oscMode)
      OSC_DRIVEN: bpNext = oscS;
      OSC_SELF: bpNext = divWrap ? !bpPhase_q : bpPhase_q;
      default: bpNext = bpPhase_q;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bpPhase_q <= 1'b0;
    end else begin
      bpPhase_q <= bpNext;
    end
  end
  assign backplane_out = bpPhase_q;

  logic [SEGS-1:0] seg_q;
  always_ff @(posedge core_clk) begin
    // xor keeps dc bias zero on every segment
    seg_q <= latch_q ^ {SEGS{bpNext}};
  end
  assign segOut = seg_q;

  // latches carry no reset; the phase check waits for a first load
  logic loaded_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      loaded_q <= 1'b0;
    end else if (loadS) begin
      loaded_q <= 1'b1;
    end
  end

  // shift path and output reset
  fifo_room_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkFall |-> fifoReady)
    else $error("serial bit dropped");
  shift_in_a: assert property (
    @(posedge core_clk) disable iff (rst)
    doShift |=> shift_q[0] == $past(bitData))
    else $error("shift did not capture input");
  shift_order_a: assert property (
    @(posedge core_clk) disable iff (rst)
    doShift |=> shift_q[SEGS-1:1] == $past(shift_q[SEGS-2:0]))
    else $error("shift order wrong");
  data_out_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkRise |=> serialOut == $past(shift_q[SEGS-1]))
    else $error("data out not updated on rise");
  data_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !clkRise |=> $stable(serialOut))
    else $error("data out changed off rise");
  out_reset_a: assert property (
    @(posedge core_clk)
    rst |=> serialOut == 1'b0 && backplane_out == 1'b0)
    else $error("outputs not cleared by reset");

  // latch and segment path
  load_copy_a: assert property (
    @(posedge core_clk)
    loadS && !doShift |=> latch_q == $past(shift_q))
    else $error("load did not copy");
  load_hold_a: assert property (
    @(posedge core_clk)
    !loadS |=> $stable(latch_q))
    else $error("latch changed without load");
  seg_phase_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(loaded_q) |->
      segOut == (latch_q ^ {SEGS{backplane_out}}) || $changed(latch_q))
    else $error("segment phase wrong");

  // backplane path
  bp_follow_a: assert property (
    @(posedge core_clk) disable iff (rst)
    oscMode == OSC_DRIVEN |=> backplane_out == $past(oscS))
    else $error("backplane not in phase with drive");
  bp_div_a: assert property (
    @(posedge core_clk) disable iff (rst)
    oscMode == OSC_SELF && !divWrap |=> $stable(backplane_out))
    else $error("backplane toggled off divider wrap");
  div_range_a: assert property (
    @(posedge core_clk) disable iff (rst)
    div_q <= 5'(DIV/2 - 1))
    else $error("divider out of range");
  mode_a: assert property (
    @(posedge core_clk) disable iff (rst)
    oscEdge |=> oscMode == OSC_SELF)
    else $error("fast osc edge not taken as rc pin");
  shift_cov: cover property (@(posedge core_clk) doShift);
  load_cov: cover property (@(posedge core_clk) loadS && doShift);
  hold_cov: cover property (@(posedge core_clk) !loadS && doShift);
  self_cov: cover property (@(posedge core_clk)
    divWrap && oscMode == OSC_SELF);
  drive_cov: cover property (@(posedge core_clk)
    oscEdge && oscMode == OSC_DRIVEN);
endmodule : sld_driver

// >>> rtl/sld_fifo.sv
// small valid/ready fifo for captured serial bits
// assumes producer and consumer share core_clk
module sld_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
  fifo_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    count_q <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : sld_fifo

// >>> rtl/sld_pkg.sv
// constants shared by the serial segment driver and its fifo
// assumes one 20 MHz core clock; pins are sampled, not used as clocks
package sld_pkg;
  localparam int SLD_SEG_COUNT = 32;
  localparam int SLD_OSC_DIV = 32;
  localparam int SLD_FIFO_DEPTH = 4;
  localparam int SLD_CORE_CLK_HZ = 20000000;
  // osc edges closer than this mean a self-oscillating rc pin
  localparam int SLD_DRIVEN_TIMEOUT_NS = 100000;
  localparam int SLD_DRIVEN_TIMEOUT_CYC =
    (SLD_DRIVEN_TIMEOUT_NS / 1000) * (SLD_CORE_CLK_HZ / 1000000);
  localparam logic [11:0] SLD_TIMEOUT_RST = 12'h000;
  localparam logic [4:0] SLD_DIV_RST = 5'h00;
endpackage : sld_pkg
